// ==== hdl/fsu_flex_serial_unit.sv ====
`timescale 1ns/100ps
`include "fsu_defs.svh"

module fsu_flex_serial_unit #(
  parameter int NSHF = 4,
  parameter int NTMR = 4,
  parameter int NPIN = 8
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Flags from the shifter and timer datapath
  input wire logic [NSHF-1:0] shf_err_flag_i,
  input wire logic [NSHF-1:0] shf_flag_i,
  input wire logic [NTMR-1:0] tmr_flag_i,
  // Timer clocks and frame bit enables
  input wire logic [NTMR-1:0] tmr_clk_i,
  input wire logic [NTMR-1:0] tmr_start_en_i,
  input wire logic [NTMR-1:0] tmr_stop_en_i,
  // Shifter serial data and frame bit sample strobes
  input wire logic [NSHF-1:0] shf_out_i,
  input wire logic [NSHF-1:0] start_smp_i,
  input wire logic [NSHF-1:0] stop_smp_i,
  output logic [NSHF-1:0] shf_in_o,
  // Per-shifter configuration, shift enables and frame errors
  output logic [NSHF-1:0][2:0] shf_mode_o,
  output logic [NSHF-1:0] shift_en_o,
  output logic [NSHF-1:0] tx_start_ins_o,
  output logic [NSHF-1:0] start_lvl_o,
  output logic [NSHF-1:0] first_shift_data_o,
  output logic [NSHF-1:0] tx_stop_ins_o,
  output logic [NSHF-1:0] stop_lvl_o,
  output logic [NSHF-1:0] frame_err_o,
  // Pins
  input wire logic [NPIN-1:0] pin_in_i,
  output logic [NPIN-1:0] pin_out_o,
  output logic [NPIN-1:0] pin_oe_o,
  // Events
  output logic irq_o,
  output logic [NSHF-1:0] dma_req_o
);

  function automatic logic [31:0] fsu_merge(input logic [31:0] old, input logic [31:0] dat,
                                            input logic [3:0] sel, input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return res & mask;
  endfunction

  logic ack_ff;
  logic [31:0] rd_ff;
  logic [31:0] err_irq_en_ff;
  logic [31:0] tmr_flag_irq_en_ff;
  logic [31:0] shf_flag_dma_en_ff;
  logic [31:0] shifter_control_ff [NSHF];
  logic [31:0] shifter_frame_config_ff [NSHF];
  logic [NTMR-1:0] tmr_clk_ff;
  logic [NSHF-1:0] shift_en_ff;
  logic [NSHF-1:0] frame_err_ff;
  logic [31:0] rd_data;
  logic [NSHF-1:0] hit_ctl;
  logic [NSHF-1:0] hit_cfg;

  fsu_cfg_if #(.NSHF(NSHF)) cfg_if ();

  // Bus decode; writes land on the edge at which ack is seen
  wire wb_req = wb_cyc_i & wb_stb_i;
  wire wb_take = wb_req & ~ack_ff;
  wire wr_en = wb_req & wb_we_i & ack_ff;
  wire [9:0] wadr = wb_adr_i[11:2];
  wire hit_err = wadr == 10'(`FSU_OFS_ERR_IRQ_EN >> 2);
  wire hit_tmr = wadr == 10'(`FSU_OFS_TMR_IRQ_EN >> 2);
  wire hit_dma = wadr == 10'(`FSU_OFS_DMA_EN >> 2);
  wire hit_sta = wadr == 10'(`FSU_OFS_STATUS >> 2);
  wire [31:0] status_word = {19'h0, irq_o, shf_flag_i, tmr_flag_i, shf_err_flag_i};

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rd_ff <= `FSU_RST_VAL;
    end else begin
      ack_ff <= wb_take;
      if (wb_take) begin
        rd_ff <= rd_data;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      err_irq_en_ff <= `FSU_RST_VAL;
      tmr_flag_irq_en_ff <= `FSU_RST_VAL;
      shf_flag_dma_en_ff <= `FSU_RST_VAL;
    end else if (wr_en) begin
      if (hit_err) begin
        err_irq_en_ff <= fsu_merge(err_irq_en_ff, wb_dat_i, wb_sel_i, `FSU_EN_MASK);
      end
      if (hit_tmr) begin
        tmr_flag_irq_en_ff <= fsu_merge(tmr_flag_irq_en_ff, wb_dat_i, wb_sel_i, `FSU_EN_MASK);
      end
      if (hit_dma) begin
        shf_flag_dma_en_ff <= fsu_merge(shf_flag_dma_en_ff, wb_dat_i, wb_sel_i, `FSU_EN_MASK);
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tmr_clk_ff <= '0;
    end else begin
      tmr_clk_ff <= tmr_clk_i;
    end
  end

  // Unmapped words read as zero and ignore writes
  always_comb begin
    rd_data = `FSU_RST_VAL;
    if (hit_err) rd_data = err_irq_en_ff;
    if (hit_tmr) rd_data = tmr_flag_irq_en_ff;
    if (hit_dma) rd_data = shf_flag_dma_en_ff;
    if (hit_sta) rd_data = status_word;
    for (int i = 0; i < NSHF; i++) begin
      if (hit_ctl[i]) rd_data = shifter_control_ff[i];
      if (hit_cfg[i]) rd_data = shifter_frame_config_ff[i];
    end
  end

  genvar s;
  generate
    for (s = 0; s < NSHF; s++) begin : g_shf
      wire [11:0] ctl_adr = `FSU_OFS_CTL + 12'(s) * `FSU_OFS_STRIDE;
      wire [11:0] cfg_adr = `FSU_OFS_CFG + 12'(s) * `FSU_OFS_STRIDE;
      assign hit_ctl[s] = wadr == ctl_adr[11:2];
      assign hit_cfg[s] = wadr == cfg_adr[11:2];

      wire [1:0] tsel = shifter_control_ff[s][`FSU_CTL_CLK_TIMER_SEL];
      wire edge_pol = shifter_control_ff[s][`FSU_CTL_EDGE];
      wire [2:0] mode_raw = shifter_control_ff[s][`FSU_CTL_MODE];
      wire [1:0] start_cfg = shifter_frame_config_ff[s][`FSU_CFG_START];
      wire [1:0] stop_cfg = shifter_frame_config_ff[s][`FSU_CFG_STOP];

      // Reserved mode codes behave as disabled
      wire mode_ok = mode_raw == fsu_pkg::FSU_MODE_RX || mode_raw == fsu_pkg::FSU_MODE_TX ||
                     mode_raw == fsu_pkg::FSU_MODE_MSTORE || mode_raw == fsu_pkg::FSU_MODE_MCONT;
      wire is_tx = mode_raw == fsu_pkg::FSU_MODE_TX;
      wire is_chk = mode_raw == fsu_pkg::FSU_MODE_RX || mode_raw == fsu_pkg::FSU_MODE_MSTORE;
      assign shf_mode_o[s] = mode_ok ? mode_raw : fsu_pkg::FSU_MODE_OFF;

      // Edge of the selected timer clock
      wire clk_now = tmr_clk_i[tsel];
      wire clk_old = tmr_clk_ff[tsel];
      wire nxt_shift_en = edge_pol ? (clk_old & ~clk_now) : (clk_now & ~clk_old);

      wire start_on = start_cfg[`FSU_BIT_ENA] & tmr_start_en_i[tsel];
      wire stop_on = stop_cfg[`FSU_BIT_ENA] & tmr_stop_en_i[tsel];
      assign tx_start_ins_o[s] = is_tx & start_on;
      assign tx_stop_ins_o[s] = is_tx & stop_on;
      assign start_lvl_o[s] = start_cfg[`FSU_BIT_LVL];
      assign stop_lvl_o[s] = stop_cfg[`FSU_BIT_LVL];
      assign first_shift_data_o[s] = ~start_cfg[`FSU_BIT_ENA] & start_cfg[`FSU_BIT_LVL];

      wire bad_start = is_chk & start_on & start_smp_i[s] &
                       (cfg_if.shf_in[s] != start_cfg[`FSU_BIT_LVL]);
      wire bad_stop = is_chk & stop_on & stop_smp_i[s] &
                      (cfg_if.shf_in[s] != stop_cfg[`FSU_BIT_LVL]);
      wire nxt_frame_err = mode_raw == fsu_pkg::FSU_MODE_RX ? (bad_start | bad_stop) :
                           (is_chk & (bad_start | bad_stop));

      always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
          shifter_control_ff[s] <= `FSU_RST_VAL;
          shifter_frame_config_ff[s] <= `FSU_RST_VAL;
          shift_en_ff[s] <= 1'b0;
          frame_err_ff[s] <= 1'b0;
        end else begin
          if (wr_en && hit_ctl[s]) begin
            shifter_control_ff[s] <= fsu_merge(shifter_control_ff[s], wb_dat_i, wb_sel_i,
                                               `FSU_CTL_MASK);
          end
          if (wr_en && hit_cfg[s]) begin
            shifter_frame_config_ff[s] <= fsu_merge(shifter_frame_config_ff[s], wb_dat_i,
                                                    wb_sel_i, `FSU_CFG_MASK);
          end
          shift_en_ff[s] <= mode_ok & nxt_shift_en;
          frame_err_ff[s] <= nxt_frame_err;
        end
      end

      assign cfg_if.pin_cfg[s] = fsu_pkg::fsu_pin_cfg_t'(shifter_control_ff[s][`FSU_CTL_PCFG]);
      assign cfg_if.pin_sel[s] = shifter_control_ff[s][`FSU_CTL_PSEL];
      assign cfg_if.pin_pol[s] = shifter_control_ff[s][`FSU_CTL_PPOL];
      assign cfg_if.in_src[s] = shifter_frame_config_ff[s][`FSU_CFG_IN_SRC_SEL];
      assign cfg_if.shf_out[s] = shf_out_i[s];
      assign shf_in_o[s] = cfg_if.shf_in[s];
    end
  endgenerate

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rd_ff;
  assign shift_en_o = shift_en_ff;
  assign frame_err_o = frame_err_ff;

  fsu_pin_mux #(.NSHF(NSHF), .NPIN(NPIN)) u_pin_mux (
    .cfg(cfg_if.pin_mux),
    .pin_in_i(pin_in_i),
    .pin_out_o(pin_out_o),
    .pin_oe_o(pin_oe_o)
  );

  // Flags reach the gate as set by the datapath
  fsu_evt_gate #(.NSHF(NSHF), .NTMR(NTMR)) u_evt_gate (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .shf_err_flag_i(shf_err_flag_i),
    .err_irq_en_i(err_irq_en_ff[NSHF-1:0]),
    .tmr_flag_i(tmr_flag_i),
    .tmr_flag_irq_en_i(tmr_flag_irq_en_ff[NTMR-1:0]),
    .shf_flag_i(shf_flag_i),
    .shf_flag_dma_en_i(shf_flag_dma_en_ff[NSHF-1:0]),
    .irq_o(irq_o),
    .dma_req_o(dma_req_o)
  );

  property p_ack_pulse;
    @(posedge mclk_i) disable iff (rst_i)
      (wb_req && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack not one cycle after request");

  property p_reset_clear;
    @(posedge mclk_i) disable iff (rst_i)
      $past(rst_i) |-> (shifter_control_ff[0] == '0 && err_irq_en_ff == '0);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("config not clear after reset");

  property p_ctl_write;
    @(posedge mclk_i) disable iff (rst_i)
      (wr_en && hit_ctl[0] && wb_sel_i == 4'hf)
      |=> shifter_control_ff[0] == ($past(wb_dat_i) & `FSU_CTL_MASK);
  endproperty
  a_ctl_write: assert property (p_ctl_write) else $error("control write lost");

  property p_shift_rise;
    @(posedge mclk_i) disable iff (rst_i)
      (g_shf[0].mode_ok && !g_shf[0].edge_pol && tmr_clk_i[g_shf[0].tsel] &&
       !tmr_clk_ff[g_shf[0].tsel]) |=> shift_en_o[0];
  endproperty
  a_shift_rise: assert property (p_shift_rise) else $error("rising shift edge missed");

  property p_shift_fall;
    @(posedge mclk_i) disable iff (rst_i)
      (g_shf[0].edge_pol && tmr_clk_i[g_shf[0].tsel]) |=> !shift_en_o[0];
  endproperty
  a_shift_fall: assert property (p_shift_fall) else $error("shift on wrong edge");

  property p_pin_pp;
    @(posedge mclk_i) disable iff (rst_i)
      cfg_if.pin_cfg[0] == fsu_pkg::FSU_PIN_PP |->
      (pin_oe_o[cfg_if.pin_sel[0]] &&
       pin_out_o[cfg_if.pin_sel[0]] == (shf_out_i[0] ^ cfg_if.pin_pol[0]));
  endproperty
  a_pin_pp: assert property (p_pin_pp) else $error("push-pull pin wrong");

  property p_pin_od;
    @(posedge mclk_i) disable iff (rst_i)
      (cfg_if.pin_cfg[0] == fsu_pkg::FSU_PIN_OD && (shf_out_i[0] ^ cfg_if.pin_pol[0]))
      |-> !pin_oe_o[cfg_if.pin_sel[0]];
  endproperty
  a_pin_od: assert property (p_pin_od) else $error("open drain drove high");

  property p_in_src;
    @(posedge mclk_i) disable iff (rst_i)
      cfg_if.in_src[0] |-> shf_in_o[0] == shf_out_i[1];
  endproperty
  a_in_src: assert property (p_in_src) else $error("cascade input wrong");

  property p_start_err;
    @(posedge mclk_i) disable iff (rst_i)
      (g_shf[0].is_chk && g_shf[0].start_on && start_smp_i[0] &&
       shf_in_o[0] != start_lvl_o[0]) |=> frame_err_o[0];
  endproperty
  a_start_err: assert property (p_start_err) else $error("start bit error missed");

endmodule

// ==== hdl/fsu_defs.svh ====
`ifndef FSU_DEFS_SVH
`define FSU_DEFS_SVH

// Byte offsets of the register words
`define FSU_OFS_ERR_IRQ_EN 12'h01c
`define FSU_OFS_TMR_IRQ_EN 12'h020
`define FSU_OFS_DMA_EN 12'h028
`define FSU_OFS_STATUS 12'h030
`define FSU_OFS_CTL 12'h080
`define FSU_OFS_CFG 12'h100
`define FSU_OFS_STRIDE 12'h004

// Writable bits of the enable, control and config registers, and the reset value of all
`define FSU_EN_MASK 32'h0000000f
`define FSU_CTL_MASK 32'h03830787
`define FSU_CFG_MASK 32'h00000133
`define FSU_RST_VAL 32'h00000000

// Shifter control fields
`define FSU_CTL_CLK_TIMER_SEL 25:24
`define FSU_CTL_EDGE 23
`define FSU_CTL_PCFG 17:16
`define FSU_CTL_PSEL 10:8
`define FSU_CTL_PPOL 7
`define FSU_CTL_MODE 2:0

// Shifter frame config fields
`define FSU_CFG_IN_SRC_SEL 8
`define FSU_CFG_STOP 5:4
`define FSU_CFG_START 1:0
`define FSU_BIT_ENA 1
`define FSU_BIT_LVL 0

`endif

// ==== hdl/fsu_pkg.sv ====
package fsu_pkg;

  typedef enum logic [2:0] {
    FSU_MODE_OFF = 3'h0,
    FSU_MODE_RX = 3'h1,
    FSU_MODE_TX = 3'h2,
    FSU_MODE_MSTORE = 3'h4,
    FSU_MODE_MCONT = 3'h5
  } fsu_mode_t;

  typedef enum logic [1:0] {
    FSU_PIN_IN = 2'h0,
    FSU_PIN_OD = 2'h1,
    FSU_PIN_CASC = 2'h2,
    FSU_PIN_PP = 2'h3
  } fsu_pin_cfg_t;

endpackage

// ==== hdl/fsu_cfg_if.sv ====
`timescale 1ns/100ps
interface fsu_cfg_if #(
  parameter int NSHF = 4,
  parameter int PSW = 3
);
  fsu_pkg::fsu_pin_cfg_t pin_cfg [NSHF];
  logic [PSW-1:0] pin_sel [NSHF];
  logic pin_pol [NSHF];
  logic in_src [NSHF];
  logic shf_out [NSHF];
  logic shf_in [NSHF];

  modport cfg_src (
    output pin_cfg, pin_sel, pin_pol, in_src, shf_out,
    input shf_in
  );
  modport pin_mux (
    input pin_cfg, pin_sel, pin_pol, in_src, shf_out,
    output shf_in
  );
endinterface

// ==== hdl/fsu_pin_mux.sv ====
`timescale 1ns/100ps
module fsu_pin_mux #(
  parameter int NSHF = 4,
  parameter int NPIN = 8
) (
  // Configuration and serial data
  fsu_cfg_if.pin_mux cfg,
  // Pins
  input wire logic [NPIN-1:0] pin_in_i,
  output logic [NPIN-1:0] pin_out_o,
  output logic [NPIN-1:0] pin_oe_o
);

  // Lower shifter index wins when two shifters claim one pin
  always_comb begin
    logic drv;
    drv = 1'b0;
    pin_out_o = '0;
    pin_oe_o = '0;
    for (int s = NSHF - 1; s >= 0; s--) begin
      drv = cfg.shf_out[s] ^ cfg.pin_pol[s];
      unique case (cfg.pin_cfg[s])
        fsu_pkg::FSU_PIN_IN: begin
        end
        fsu_pkg::FSU_PIN_OD: begin
          pin_out_o[cfg.pin_sel[s]] = 1'b0;
          pin_oe_o[cfg.pin_sel[s]] = ~drv;
        end
        fsu_pkg::FSU_PIN_CASC, fsu_pkg::FSU_PIN_PP: begin
          pin_out_o[cfg.pin_sel[s]] = drv;
          pin_oe_o[cfg.pin_sel[s]] = 1'b1;
        end
      endcase
    end
  end

  genvar s;
  generate
    for (s = 0; s < NSHF; s++) begin : g_in
      if (s < NSHF - 1) begin : g_casc
        assign cfg.shf_in[s] = cfg.in_src[s] ? cfg.shf_out[s+1] :
                               (pin_in_i[cfg.pin_sel[s]] ^ cfg.pin_pol[s]);
      end else begin : g_last
        assign cfg.shf_in[s] = pin_in_i[cfg.pin_sel[s]] ^ cfg.pin_pol[s];
      end
    end
  endgenerate

endmodule

// ==== hdl/fsu_evt_gate.sv ====
`timescale 1ns/100ps
module fsu_evt_gate #(
  parameter int NSHF = 4,
  parameter int NTMR = 4
) (
  // Clock and reset, used by checks only
  input wire logic mclk_i,
  input wire logic rst_i,
  // Flags and enables
  input wire logic [NSHF-1:0] shf_err_flag_i,
  input wire logic [NSHF-1:0] err_irq_en_i,
  input wire logic [NTMR-1:0] tmr_flag_i,
  input wire logic [NTMR-1:0] tmr_flag_irq_en_i,
  input wire logic [NSHF-1:0] shf_flag_i,
  input wire logic [NSHF-1:0] shf_flag_dma_en_i,
  // Requests
  output logic irq_o,
  output logic [NSHF-1:0] dma_req_o
);

  wire [NSHF-1:0] err_pend = shf_err_flag_i & err_irq_en_i;
  wire [NTMR-1:0] tmr_pend = tmr_flag_i & tmr_flag_irq_en_i;

  assign irq_o = (|err_pend) | (|tmr_pend);
  assign dma_req_o = shf_flag_i & shf_flag_dma_en_i;

  property p_err_irq;
    @(posedge mclk_i) disable iff (rst_i)
      (shf_err_flag_i[0] && err_irq_en_i[0]) |-> irq_o;
  endproperty
  a_err_irq: assert property (p_err_irq) else $error("error flag did not raise irq");

  property p_tmr_irq;
    @(posedge mclk_i) disable iff (rst_i)
      (tmr_flag_i[3] && tmr_flag_irq_en_i[3]) |-> irq_o;
  endproperty
  a_tmr_irq: assert property (p_tmr_irq) else $error("timer flag did not raise irq");

  property p_irq_quiet;
    @(posedge mclk_i) disable iff (rst_i)
      ((shf_err_flag_i & err_irq_en_i) == '0 && (tmr_flag_i & tmr_flag_irq_en_i) == '0)
      |-> !irq_o;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq without enabled flag");

  property p_dma_gate;
    @(posedge mclk_i) disable iff (rst_i)
      (shf_flag_i[0] && !shf_flag_dma_en_i[0]) |-> !dma_req_o[0];
  endproperty
  a_dma_gate: assert property (p_dma_gate) else $error("dma request while disabled");

endmodule

// ==== testbench/fsu_ext_dev.sv ====
`timescale 1ns/100ps
module fsu_ext_dev #(
  parameter int NPIN = 8
) (
  // Unit side of the pins
  input wire logic [NPIN-1:0] pin_out_i,
  input wire logic [NPIN-1:0] pin_oe_i,
  // What the far device puts on the pins
  input wire logic [NPIN-1:0] drv_val_i,
  input wire logic [NPIN-1:0] drv_en_i,
  // Resolved pin levels
  output logic [NPIN-1:0] pin_o
);
  // The unit wins where it drives, then the far device; a pin neither drives floats up to the pull-up
  always_comb begin
    for (int k = 0; k < NPIN; k++) begin
      pin_o[k] = pin_oe_i[k] ? pin_out_i[k] : (drv_en_i[k] ? drv_val_i[k] : 1'b1);
    end
  end
endmodule

// ==== testbench/fsu_flex_serial_unit_bench.sv ====
`timescale 1ns/100ps
`include "fsu_defs.svh"
module fsu_flex_serial_unit_bench;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, rdat, got;
  logic [3:0] err_f = 4'h0, shf_f = 4'h0, tmr_f = 4'h0, tclk = 4'h0;
  logic [3:0] tst_en = 4'h0, tsp_en = 4'h0, sout = 4'h0, st_smp = 4'h0, sp_smp = 4'h0;
  logic [7:0] drv_val = 8'h00, drv_en = 8'h00, pin_w, p_out, p_oe;
  logic ack, irq, e_oe, e_out;
  logic [3:0] shf_in, sh_en, ts_ins, ts_lvl, fsd, tp_ins, tp_lvl, ferr, dma;
  logic [3:0][2:0] mode;
  logic [11:0] ofs [8];
  logic [31:0] msk [8];
  logic [3:0] fcase [6];
  int errors = 0, n_compared = 0, cycles = 0, se_cnt = 0, fe_cnt = 0, s;

  always #2.5 mclk_i = ~mclk_i;

  fsu_flex_serial_unit #(.NSHF(4), .NTMR(4), .NPIN(8)) i_fsu_flex_serial_unit (
    .mclk_i(mclk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .shf_err_flag_i(err_f), .shf_flag_i(shf_f), .tmr_flag_i(tmr_f), .tmr_clk_i(tclk),
    .tmr_start_en_i(tst_en), .tmr_stop_en_i(tsp_en), .shf_out_i(sout),
    .start_smp_i(st_smp), .stop_smp_i(sp_smp), .shf_in_o(shf_in), .shf_mode_o(mode),
    .shift_en_o(sh_en), .tx_start_ins_o(ts_ins), .start_lvl_o(ts_lvl),
    .first_shift_data_o(fsd), .tx_stop_ins_o(tp_ins), .stop_lvl_o(tp_lvl),
    .frame_err_o(ferr), .pin_in_i(pin_w), .pin_out_o(p_out), .pin_oe_o(p_oe),
    .irq_o(irq), .dma_req_o(dma));

  fsu_ext_dev #(.NPIN(8)) i_fsu_ext_dev (.pin_out_i(p_out), .pin_oe_i(p_oe),
    .drv_val_i(drv_val), .drv_en_i(drv_en), .pin_o(pin_w));

  task automatic close_out();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge mclk_i) begin
    se_cnt <= se_cnt + int'(sh_en[0]);
    fe_cnt <= fe_cnt + int'(ferr[0]);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %0t %s: saw %h want %h", $time, what, seen, exp);
    end
  endtask

  // Classic single cycle: hold everything until ack is sampled high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    dat <= d;
    do begin
      @(posedge mclk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    got = rdat;
    if (ack !== 1'b1) chk(32'h0, 32'h1, "no ack");
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(got, exp, "read");
  endtask

  function automatic logic [31:0] ctl(input logic [1:0] ts, input logic ed,
      input logic [1:0] pc, input logic [2:0] ps, input logic pp, input logic [2:0] md);
    return {6'h0, ts, ed, 5'h0, pc, 5'h0, ps, pp, 4'h0, md};
  endfunction

  // Counts shift pulses that follow one change of the timer clocks
  task automatic clk_step(input logic [3:0] v, input logic [31:0] exp);
    @(posedge mclk_i);
    tclk <= v;
    @(negedge mclk_i);
    s = se_cnt;
    repeat (6) @(negedge mclk_i);
    chk(32'(se_cnt - s), exp, "shift pulses");
  endtask

  initial begin
    ofs = '{`FSU_OFS_ERR_IRQ_EN, `FSU_OFS_TMR_IRQ_EN, `FSU_OFS_DMA_EN, `FSU_OFS_CTL,
      `FSU_OFS_CTL + 12'h00c, `FSU_OFS_CFG, `FSU_OFS_CFG + 12'h00c, 12'h040};
    msk = '{`FSU_EN_MASK, `FSU_EN_MASK, `FSU_EN_MASK, `FSU_CTL_MASK, `FSU_CTL_MASK,
      `FSU_CFG_MASK, `FSU_CFG_MASK, 32'h0};
    // Columns: timer frame bits on, stop strobe, pin level, error expected
    fcase = '{4'b1011, 4'b1000, 4'b1110, 4'b1101, 4'b0010, 4'b0100};
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(negedge mclk_i);
    chk({p_oe, irq, dma}, 32'h0, "reset outputs");
    for (int k = 0; k < 8; k++) begin
      rd(ofs[k], 32'h0);
      wr(ofs[k], msk[k]);
      rd(ofs[k], msk[k]);
      wr(ofs[k], 32'h0);
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk_i);
      err_f <= 4'h1 << i;
      tmr_f <= 4'h0;
      wr(`FSU_OFS_ERR_IRQ_EN, ~(32'h1 << i) & 32'hf);
      @(negedge mclk_i);
      chk(irq, 1'b0, "masked error");
      wr(`FSU_OFS_ERR_IRQ_EN, 32'h1 << i);
      @(negedge mclk_i);
      chk(irq, 1'b1, "error irq");
      wr(`FSU_OFS_ERR_IRQ_EN, 32'h0);
      @(posedge mclk_i);
      err_f <= 4'h0;
      tmr_f <= 4'h1 << i;
      @(negedge mclk_i);
      chk(irq, 1'b0, "masked timer");
      wr(`FSU_OFS_TMR_IRQ_EN, 32'h1 << i);
      @(negedge mclk_i);
      chk(irq, 1'b1, "timer irq");
      wr(`FSU_OFS_TMR_IRQ_EN, 32'h0);
      @(posedge mclk_i);
      shf_f <= 4'h5;
      wr(`FSU_OFS_DMA_EN, 32'h1 << i);
      @(negedge mclk_i);
      chk(dma, 4'h5 & (4'h1 << i), "dma");
      rd(`FSU_OFS_STATUS, 32'h500 | (32'h10 << i));
    end
    wr(`FSU_OFS_DMA_EN, 32'h0);
    for (int m = 0; m < 8; m++) begin
      wr(`FSU_OFS_CTL, 32'(m));
      @(negedge mclk_i);
      chk(mode[0], (m == 3 || m > 5) ? 3'h0 : 3'(m), "mode");
    end
    for (int c = 0; c < 16; c++) begin
      wr(`FSU_OFS_CTL, ctl(2'h0, 1'b0, c[3:2], 3'h5, c[1], 3'h2));
      @(posedge mclk_i);
      sout <= {3'h0, c[0]};
      @(negedge mclk_i);
      e_oe = (c[3:2] == 2'h0) ? 1'b0 : (c[3:2] == 2'h1) ? ~(c[0] ^ c[1]) : 1'b1;
      e_out = c[3] & (c[0] ^ c[1]);
      chk({p_oe, p_out[5] & p_oe[5]}, {{2'h0, e_oe, 5'h0}, e_out}, "pin out");
    end
    for (int v = 0; v < 4; v++) begin
      wr(`FSU_OFS_CTL, ctl(2'h0, 1'b0, 2'h0, 3'h5, v[1], 3'h1));
      @(posedge mclk_i);
      drv_en <= 8'h20;
      drv_val <= {2'h0, v[0], 5'h0};
      @(negedge mclk_i);
      chk(shf_in[0], v[0] ^ v[1], "pin in");
    end
    wr(`FSU_OFS_CFG, 32'h100);
    @(posedge mclk_i);
    sout <= 4'h2;
    @(negedge mclk_i);
    chk(shf_in[0], 1'b1, "cascade in");
    wr(`FSU_OFS_CTL, ctl(2'h2, 1'b0, 2'h0, 3'h0, 1'b0, 3'h2));
    wr(`FSU_OFS_CFG, 32'h32);
    @(posedge mclk_i);
    tst_en <= 4'h4;
    tsp_en <= 4'h4;
    @(negedge mclk_i);
    chk({ts_ins[0], ts_lvl[0], tp_ins[0], tp_lvl[0], fsd[0]}, 5'b10110, "tx bits");
    @(posedge mclk_i);
    tsp_en <= 4'hb;
    wr(`FSU_OFS_CFG, 32'h21);
    @(negedge mclk_i);
    chk({ts_ins[0], ts_lvl[0], tp_ins[0], tp_lvl[0], fsd[0]}, 5'b01001, "tx bits 2");
    wr(`FSU_OFS_CTL, ctl(2'h1, 1'b0, 2'h0, 3'h2, 1'b0, 3'h1));
    wr(`FSU_OFS_CFG, 32'h32);
    for (int f = 0; f < 6; f++) begin
      @(posedge mclk_i);
      tst_en <= {2'h0, fcase[f][3], 1'b0};
      tsp_en <= {2'h0, fcase[f][3], 1'b0};
      drv_en <= 8'h04;
      drv_val <= {5'h0, fcase[f][1], 2'h0};
      @(posedge mclk_i);
      s = fe_cnt;
      st_smp <= {3'h0, ~fcase[f][2]};
      sp_smp <= {3'h0, fcase[f][2]};
      @(posedge mclk_i);
      st_smp <= 4'h0;
      sp_smp <= 4'h0;
      repeat (4) @(negedge mclk_i);
      chk(32'(fe_cnt - s), {31'h0, fcase[f][0]}, "frame error");
    end
    for (int t = 0; t < 4; t++) begin
      for (int e = 0; e < 2; e++) begin
        wr(`FSU_OFS_CTL, ctl(t[1:0], e[0], 2'h0, 3'h0, 1'b0, 3'h1));
        clk_step(4'h1 << ((t + 1) % 4), 32'h0);
        clk_step((4'h1 << ((t + 1) % 4)) | (4'h1 << t), {31'h0, ~e[0]});
        clk_step(4'h0, {31'h0, e[0]});
      end
    end
    wr(`FSU_OFS_ERR_IRQ_EN, 32'h5);
    @(posedge mclk_i);
    rst_i <= 1'b1;
    @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(`FSU_OFS_CTL, 32'h0);
    rd(`FSU_OFS_ERR_IRQ_EN, 32'h0);
    close_out();
  end
endmodule
